// [core/timer_c_pkg.sv]
// Purpose: constants for the 8-bit up/down auto-reload timer
// Assumes: 32-bit APB, one aligned word per register
// Notes: only the low 8 bits of each word are used
package timer_c_pkg;
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_CKSTP = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
    localparam logic [7:0] ADDR_PIN_CFG = 8'h18;

    localparam logic [7:0] MODE_RESET = 8'h18;
    localparam logic [7:0] MODE_RSVD_ONES = 8'h18;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] CKSTP_RESET = 8'hff;
    localparam logic [2:0] PIN_CFG_RESET = 3'h0;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_MIN = 8'h00;

    localparam int RELOAD_MODE_BIT = 7;
    localparam int HW_DIR_BIT = 6;
    localparam int SW_DIR_BIT = 5;
    localparam int STANDBY_REL_BIT = 1;
    localparam int TREQ_BIT = 0;
    localparam int EDGE_RISE_BIT = 0;
    localparam int EVT_PIN_EN_BIT = 1;
    localparam int DIR_PIN_EN_BIT = 2;

    localparam logic [2:0] CKS_DIV8192 = 3'h0;
    localparam logic [2:0] CKS_DIV2048 = 3'h1;
    localparam logic [2:0] CKS_DIV512 = 3'h2;
    localparam logic [2:0] CKS_DIV64 = 3'h3;
    localparam logic [2:0] CKS_DIV16 = 3'h4;
    localparam logic [2:0] CKS_DIV4 = 3'h5;
    localparam logic [2:0] CKS_SUB4 = 3'h6;
    localparam logic [2:0] CKS_EVENT = 3'h7;

    localparam int PRESC_W = 13;
    localparam logic [12:0] PRESC_8192_END = 13'h1fff;
    localparam logic [12:0] PRESC_2048_END = 13'h07ff;
    localparam logic [12:0] PRESC_512_END = 13'h01ff;
    localparam logic [12:0] PRESC_64_END = 13'h003f;
    localparam logic [12:0] PRESC_16_END = 13'h000f;
    localparam logic [12:0] PRESC_4_END = 13'h0003;
    localparam logic [1:0] SUB_DIV_END = 2'h3;
endpackage

// [core/updown_reload_timer_8bit.sv]
// Purpose: 8-bit up/down timer, interval or auto-reload, APB slave
// Assumes: pins synchronous inputs, sub_clk slower than core_clk / 2
// Notes: zero-wait APB, read data captured in the setup cycle
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module updown_reload_timer_8bit
    import timer_c_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic event_input_pin,
    input wire logic direction_pin,
    input wire logic sub_clk,
    output logic irq
);
    logic [7:0] timer_c_mode;
    logic [7:0] timer_c_count;
    logic [7:0] timer_c_reload;
    logic [7:0] module_clock_stop_one;
    logic [2:0] pin_cfg;
    logic timer_request_flag;
    logic timer_request_enable;
    logic [PRESC_W-1:0] presc;
    logic evt_s1, evt_s2, evt_s3;
    logic dir_s1, dir_s2;
    logic sub_s1, sub_s2, sub_s3;
    logic [1:0] sub_div;
    logic setup, access, wr_acc;
    logic reload_wr, clr_wr;
    logic mapped;
    logic [7:0] rd_byte;
    logic [2:0] clock_source_select;
    logic reload_mode_select, hw_direction_select, sw_direction_select;
    logic run, count_down;
    logic evt_edge, sub_tick, src_tick, step;
    logic wrap_up, wrap_down, wrap;
    logic [7:0] next_count;

    assign clock_source_select = timer_c_mode[2:0];
    assign reload_mode_select = timer_c_mode[RELOAD_MODE_BIT];
    assign hw_direction_select = timer_c_mode[HW_DIR_BIT];
    assign sw_direction_select = timer_c_mode[SW_DIR_BIT];
    assign run = module_clock_stop_one[STANDBY_REL_BIT];

    // apb decode, no wait states
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr_acc = access & pwrite;
    assign pready = 1'b1;
    assign reload_wr = wr_acc & (paddr == ADDR_COUNT);
    assign clr_wr = wr_acc & (paddr == ADDR_IRQ_CLR);
    assign mapped = (paddr == ADDR_MODE) || (paddr == ADDR_COUNT)
        || (paddr == ADDR_CKSTP) || (paddr == ADDR_IRQ_STAT)
        || (paddr == ADDR_IRQ_CLR) || (paddr == ADDR_IRQ_EN)
        || (paddr == ADDR_PIN_CFG);

    always_comb
    begin
        case (paddr)
            ADDR_MODE: rd_byte = timer_c_mode | MODE_RSVD_ONES;
            ADDR_COUNT: rd_byte = timer_c_count;
            ADDR_CKSTP: rd_byte = module_clock_stop_one;
            ADDR_IRQ_STAT: rd_byte = {7'h00, timer_request_flag};
            ADDR_IRQ_EN: rd_byte = {7'h00, timer_request_enable};
            ADDR_PIN_CFG: rd_byte = {5'h00, pin_cfg};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= {24'h00_0000, pwrite ? 8'h00 : rd_byte};
            pslverr <= ~mapped;
        end
    end

    // writable registers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            timer_c_mode <= MODE_RESET;
            module_clock_stop_one <= CKSTP_RESET;
            timer_request_enable <= 1'b0;
            pin_cfg <= PIN_CFG_RESET;
            timer_c_reload <= RELOAD_RESET;
        end
        else if (wr_acc)
        begin
            case (paddr)
                ADDR_MODE: timer_c_mode <= (pwdata[7:0] & ~MODE_RSVD_ONES)
                    | MODE_RSVD_ONES;
                ADDR_COUNT: timer_c_reload <= pwdata[7:0];
                ADDR_CKSTP: module_clock_stop_one <= pwdata[7:0];
                ADDR_IRQ_EN: timer_request_enable <= pwdata[TREQ_BIT];
                ADDR_PIN_CFG: pin_cfg <= pwdata[2:0];
                default: timer_request_enable <= timer_request_enable;
            endcase
        end
    end

    // free-running prescaler
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            presc <= '0;
        else
            presc <= presc + 1'b1;
    end

    // pin synchronisers, third stage only for edge detection
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            evt_s1 <= 1'b0;
            evt_s2 <= 1'b0;
            evt_s3 <= 1'b0;
            dir_s1 <= 1'b0;
            dir_s2 <= 1'b0;
            sub_s1 <= 1'b0;
            sub_s2 <= 1'b0;
            sub_s3 <= 1'b0;
        end
        else
        begin
            evt_s1 <= event_input_pin;
            evt_s2 <= evt_s1;
            evt_s3 <= evt_s2;
            dir_s1 <= direction_pin;
            dir_s2 <= dir_s1;
            sub_s1 <= sub_clk;
            sub_s2 <= sub_s1;
            sub_s3 <= sub_s2;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            sub_div <= 2'h0;
        else if (sub_s2 & ~sub_s3)
            sub_div <= sub_div + 2'h1;
    end

    assign sub_tick = sub_s2 & ~sub_s3 & (sub_div == SUB_DIV_END);
    // event pin ignored unless its pin function is on
    assign evt_edge = pin_cfg[EVT_PIN_EN_BIT]
        & (pin_cfg[EDGE_RISE_BIT] ? (evt_s2 & ~evt_s3)
        : (~evt_s2 & evt_s3));

    always_comb
    begin
        case (clock_source_select)
            CKS_DIV8192: src_tick = (presc & PRESC_8192_END) == PRESC_8192_END;
            CKS_DIV2048: src_tick = (presc & PRESC_2048_END) == PRESC_2048_END;
            CKS_DIV512: src_tick = (presc & PRESC_512_END) == PRESC_512_END;
            CKS_DIV64: src_tick = (presc & PRESC_64_END) == PRESC_64_END;
            CKS_DIV16: src_tick = (presc & PRESC_16_END) == PRESC_16_END;
            CKS_DIV4: src_tick = (presc & PRESC_4_END) == PRESC_4_END;
            CKS_SUB4: src_tick = sub_tick;
            CKS_EVENT: src_tick = evt_edge;
            default: src_tick = 1'b0;
        endcase
    end

    // direction pin reads low (up) while its pin function is off
    assign count_down = hw_direction_select
        ? (dir_s2 & pin_cfg[DIR_PIN_EN_BIT])
        : sw_direction_select;
    assign step = run & src_tick;
    assign wrap_up = step & ~count_down & (timer_c_count == COUNT_MAX);
    assign wrap_down = step & count_down & (timer_c_count == COUNT_MIN);
    assign wrap = wrap_up | wrap_down;

    always_comb
    begin
        next_count = timer_c_count;
        if (reload_wr)
            next_count = pwdata[7:0];
        else if (wrap & reload_mode_select)
            next_count = timer_c_reload;
        else if (step & count_down)
            next_count = timer_c_count - 8'h01;
        else if (step)
            next_count = timer_c_count + 8'h01;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            timer_c_count <= COUNT_RESET;
        else
            timer_c_count <= next_count;
    end

    // a wrap in the clearing cycle keeps the flag set
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            timer_request_flag <= 1'b0;
        else if (wrap & ~reload_wr)
            timer_request_flag <= 1'b1;
        else if (clr_wr & pwdata[TREQ_BIT])
            timer_request_flag <= 1'b0;
    end

    assign irq = timer_request_flag & timer_request_enable;

    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (rst);

    AST_MODE_RSVD: assert property (
        wr_acc && paddr == ADDR_MODE |=> timer_c_mode[4:3] == 2'b11)
        else $error("reserved mode bits not one");
    AST_SW_DIR: assert property (
        step && !reload_wr && !wrap && timer_c_mode[6:5] == 2'b01
        |=> timer_c_count == $past(timer_c_count) - 8'h01)
        else $error("software down count did not decrement");
    AST_HW_DIR: assert property (
        step && !reload_wr && !wrap && hw_direction_select
        && pin_cfg[DIR_PIN_EN_BIT] && !dir_s2
        |=> timer_c_count == $past(timer_c_count) + 8'h01)
        else $error("pin low did not count up");
    // a step seen one cycle late: source, standby and reload are taken from that cycle
    AST_DIV64: assert property (
        $past(run) && $past(clock_source_select) == CKS_DIV64 && !$past(reload_wr)
        && $changed(timer_c_count) |-> presc[5:0] == 6'h00)
        else $error("divide by 64 step off its boundary");
    AST_DIV2048: assert property (
        $past(run) && $past(clock_source_select) == CKS_DIV2048 && !$past(reload_wr)
        && $changed(timer_c_count) |-> presc[10:0] == 11'h000)
        else $error("divide by 2048 step off its boundary");
    AST_READ: assert property (
        setup && !pwrite && paddr == ADDR_COUNT
        |=> prdata[7:0] == $past(timer_c_count) && pready)
        else $error("count read returned wrong value");
    AST_LOAD: assert property (
        reload_wr |=> timer_c_count == $past(pwdata[7:0])
        && timer_c_reload == $past(pwdata[7:0]))
        else $error("reload write did not load counter");
    AST_WRAP_UP: assert property (
        wrap_up && !reload_wr && !reload_mode_select
        |=> timer_c_count == 8'h00 ##0 timer_request_flag)
        else $error("interval overflow did not wrap");
    AST_WRAP_DOWN: assert property (
        wrap_down && !reload_wr && !reload_mode_select
        |=> timer_c_count == 8'hff)
        else $error("interval underflow did not wrap");
    AST_AUTO: assert property (
        wrap && !reload_wr && reload_mode_select
        |=> timer_c_count == $past(timer_c_reload))
        else $error("auto-reload not applied");
    AST_FLAG: assert property (
        wrap && !reload_wr |=> timer_request_flag [*1] ##1 1'b1)
        else $error("wrap did not set request flag");
    AST_IRQ: assert property (
        wrap && !reload_wr && timer_request_enable && !wr_acc |=> irq)
        else $error("enabled request did not raise irq");
    AST_STANDBY: assert property (
        !run && !reload_wr |=> $stable(timer_c_count))
        else $error("counter moved in standby");
    AST_ONE_STEP: assert property (
        run && clock_source_select == CKS_EVENT && !reload_wr && !evt_edge
        |=> $stable(timer_c_count))
        else $error("event counter stepped without edge");
    AST_RESET_RUN: assert property (
        $fell(rst) |-> timer_c_mode == MODE_RESET && run)
        else $error("reset mode wrong");

    // one step per counting clock, in either direction
    AST_UP_STEP: assert property (
        step && !reload_wr && !wrap && !count_down
        |=> timer_c_count == $past(timer_c_count) + 8'h01)
        else $error("up count did not increment");
    AST_HW_DOWN: assert property (
        step && !reload_wr && !wrap && hw_direction_select
        && pin_cfg[DIR_PIN_EN_BIT] && dir_s2
        |=> timer_c_count == $past(timer_c_count) - 8'h01)
        else $error("pin high did not count down");
    AST_EVT_STEP: assert property (
        run && clock_source_select == CKS_EVENT && evt_edge && !reload_wr && !wrap
        |=> $changed(timer_c_count))
        else $error("event edge did not step counter");

    // prescaler boundaries for the remaining internal sources, then the subclock divide by 4
    AST_DIV8192: assert property (
        $past(run) && $past(clock_source_select) == CKS_DIV8192 && !$past(reload_wr)
        && $changed(timer_c_count) |-> presc[12:0] == 13'h0000)
        else $error("divide by 8192 step off its boundary");
    AST_DIV512: assert property (
        $past(run) && $past(clock_source_select) == CKS_DIV512 && !$past(reload_wr)
        && $changed(timer_c_count) |-> presc[8:0] == 9'h000)
        else $error("divide by 512 step off its boundary");
    AST_DIV16: assert property (
        $past(run) && $past(clock_source_select) == CKS_DIV16 && !$past(reload_wr)
        && $changed(timer_c_count) |-> presc[3:0] == 4'h0)
        else $error("divide by 16 step off its boundary");
    AST_DIV4: assert property (
        $past(run) && $past(clock_source_select) == CKS_DIV4 && !$past(reload_wr)
        && $changed(timer_c_count) |-> presc[1:0] == 2'h0)
        else $error("divide by 4 step off its boundary");
    AST_SUB4: assert property (
        $past(run) && $past(clock_source_select) == CKS_SUB4 && !$past(reload_wr)
        && $changed(timer_c_count)
        |-> $past(sub_s2) && !$past(sub_s3) && $past(sub_div) == SUB_DIV_END)
        else $error("subclock step not on every fourth edge");

    // request flag and interrupt
    AST_FLAG_CLR: assert property (
        clr_wr && pwdata[TREQ_BIT] && !wrap |=> !timer_request_flag)
        else $error("request flag not cleared");
    AST_FLAG_ONLY_WRAP: assert property (
        !timer_request_flag && !(wrap && !reload_wr) |=> !timer_request_flag)
        else $error("request flag set without wrap");
    AST_FLAG_HOLD: assert property (
        timer_request_flag && !clr_wr |=> timer_request_flag)
        else $error("request flag dropped without clear");
    AST_IRQ_EN_OFF: assert property (
        wr_acc && paddr == ADDR_IRQ_EN && !pwdata[TREQ_BIT] |=> !irq)
        else $error("disabled request still raises irq");

    // register interface
    AST_RELOAD_KEEP: assert property (
        !reload_wr |=> $stable(timer_c_reload))
        else $error("reload value changed without a write");
    AST_MODE_READ: assert property (
        setup && !pwrite && paddr == ADDR_MODE |=> prdata[4:3] == 2'b11)
        else $error("reserved mode bits read zero");
    AST_SLVERR: assert property (
        setup && !mapped |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    AST_SLVERR_OK: assert property (
        setup && mapped |=> !pslverr)
        else $error("mapped access refused");
    AST_RD_HOLD: assert property (
        !setup |=> $stable(prdata) && $stable(pslverr))
        else $error("read data moved outside setup");
    AST_RESET_STANDBY: assert property (
        $fell(rst)
        |-> module_clock_stop_one == CKSTP_RESET && timer_c_count == COUNT_RESET)
        else $error("reset clock stop or count wrong");

    CV_AUTO: cover property (wrap_up && reload_mode_select);
    CV_UNDER: cover property (wrap_down && !reload_mode_select);
    CV_EVENT: cover property (step && clock_source_select == CKS_EVENT);
    CV_IRQ: cover property ($rose(irq));
    CV_HW_DOWN: cover property (step && hw_direction_select && count_down);
endmodule

// [test/timer_pins_model.sv]
// Purpose: far-side pins of the timer: event input, direction input, subclock
// Assumes: event and direction pins change only just after a core clock edge
// Notes: subclock runs free with a 40 ns period, exactly eight 5 ns core clock periods
`timescale 1ns/100ps
module timer_pins_model
(
    input wire logic core_clk,
    output logic event_input_pin,
    output logic direction_pin,
    output logic sub_clk
);
    initial
    begin
        event_input_pin = 1'h0;
        direction_pin = 1'h0;
        sub_clk = 1'h0;
    end

    always #20 sub_clk = ~sub_clk;

    // pulses wide enough for the two-stage synchroniser to see both edges
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            event_input_pin <= 1'h1;
            repeat (4) @(posedge core_clk);
            event_input_pin <= 1'h0;
            repeat (4) @(posedge core_clk);
        end
    endtask

    task automatic set_dir(input logic d);
        @(posedge core_clk);
        direction_pin <= d;
        repeat (4) @(posedge core_clk);
    endtask
endmodule

// [test/tb_updown_reload_timer_8bit.sv]
// Purpose: self-checking bench for the 8-bit up/down reload timer
// Assumes: zero-wait APB slave, pins driven by the far-side model
// Notes: expected read values are queued by the driver and checked by a monitor
`timescale 1ns/100ps
module tb_updown_reload_timer_8bit
    import timer_c_pkg::*;
;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, event_input_pin, direction_pin, sub_clk, irq;
    logic [32:0] exp_q[$];
    logic [31:0] seed = 32'h000027c7;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    int divs[7] = '{8192, 2048, 512, 64, 16, 4, 32};

    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    updown_reload_timer_8bit i_updown_reload_timer_8bit (.core_clk(core_clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .event_input_pin(event_input_pin), .direction_pin(direction_pin), .sub_clk(sub_clk));

    timer_pins_model i_timer_pins_model (.core_clk(core_clk),
        .event_input_pin(event_input_pin), .direction_pin(direction_pin), .sub_clk(sub_clk));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic fail(input string s, input logic [32:0] e, input logic [32:0] g);
        $display("wrong value %s expected %h seen %h", s, e, g);
        err_total++;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'h1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'h1 && n < 20);
        if (n >= 20)
        begin
            fail("pready", 1, 0);
            results();
        end
        else
        begin
            psel <= 1'h0;
            penable <= 1'h0;
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic er = 1'h0);
        exp_q.push_back({er, 24'h0, e});
        apb(1'h0, a, 8'h00);
    endtask

    // monitor: each completed read takes the oldest queued expectation
    always @(posedge core_clk)
    begin
        if (psel && penable && pready === 1'h1 && !pwrite && exp_q.size() > 0)
        begin
            checked++;
            if ({pslverr, prdata} !== exp_q[0])
                fail($sformatf("read %h", paddr), exp_q[0], {pslverr, prdata});
            void'(exp_q.pop_front());
        end
    end

    task automatic chk_irq(input logic e);
        #1;
        checked++;
        if (irq !== e)
            fail("irq", e, irq);
    endtask

    task automatic wirq(output int t);
        int n;
        n = 0;
        #1;
        while (irq !== 1'h1 && n < 20000)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= 20000)
        begin
            fail("irq wait", 1, 0);
            results();
        end
        else
            t = cyc;
    endtask

    task automatic ev(input logic [7:0] m, input logic [7:0] l, input int n, input logic [7:0] e);
        apb(1'h1, ADDR_MODE, m);
        apb(1'h1, ADDR_COUNT, l);
        i_timer_pins_model.pulse(n);
        rd(ADDR_COUNT, e);
    endtask

    initial
    begin
        logic [7:0] r;
        int k, t0, t1;
        repeat (6) @(posedge core_clk);
        rst <= 1'h0;
        rd(ADDR_MODE, 8'h18);
        rd(ADDR_COUNT, 8'h00);
        rd(ADDR_CKSTP, 8'hff);
        rd(ADDR_IRQ_STAT, 8'h00);
        rd(8'h1c, 8'h00, 1'h1);
        apb(1'h1, ADDR_CKSTP, 8'hfd);
        apb(1'h1, ADDR_PIN_CFG, 8'h03);
        ev(8'h07, 8'h40, 1, 8'h40);
        rd(ADDR_MODE, 8'h1f);
        apb(1'h1, ADDR_CKSTP, 8'hff);
        i_timer_pins_model.pulse(1);
        rd(ADDR_COUNT, 8'h41);
        repeat (4)
        begin
            r = 8'(rnd());
            k = 1 + int'(rnd() % 3);
            apb(1'h1, ADDR_IRQ_CLR, 8'h01);
            ev(8'h07, r, k, 8'(int'(r) + k));
            rd(ADDR_IRQ_STAT, 8'(int'(r) + k > 255));
        end
        apb(1'h1, ADDR_IRQ_EN, 8'h01);
        apb(1'h1, ADDR_IRQ_CLR, 8'h01);
        chk_irq(1'h0);
        ev(8'h27, 8'h01, 2, 8'hff);
        chk_irq(1'h1);
        ev(8'h87, 8'hfe, 2, 8'hfe);
        ev(8'ha7, 8'h01, 2, 8'h01);
        apb(1'h1, ADDR_PIN_CFG, 8'h07);
        i_timer_pins_model.set_dir(1'h1);
        ev(8'h47, 8'h10, 1, 8'h0f);
        i_timer_pins_model.set_dir(1'h0);
        ev(8'h67, 8'h10, 1, 8'h11);
        apb(1'h1, ADDR_PIN_CFG, 8'h02);
        ev(8'h07, 8'h20, 2, 8'h22);
        foreach (divs[i])
        begin
            apb(1'h1, ADDR_MODE, 8'h80 | 8'(i));
            apb(1'h1, ADDR_COUNT, 8'hfe);
            apb(1'h1, ADDR_IRQ_CLR, 8'h01);
            wirq(t0);
            apb(1'h1, ADDR_IRQ_CLR, 8'h01);
            wirq(t1);
            checked++;
            if (t1 - t0 != 2 * divs[i])
                fail("tick period", 2 * divs[i], t1 - t0);
        end
        apb(1'h1, ADDR_IRQ_EN, 8'h00);
        chk_irq(1'h0);
        rd(ADDR_IRQ_STAT, 8'h01);
        @(posedge core_clk);
        results();
    end
endmodule
